/* File: shared/eph_pkg.sv */
// eph_pkg: constants for the page-write eeprom host controller
package eph_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ        = 100;           // system clock rate
    localparam int WP_NS          = 350;           // write strobe low width, slowest grade
    localparam int BLC_MIN_NS     = 950;           // least byte load cycle
    localparam int BLC_MAX_US     = 30;            // byte load window per byte
    localparam int LOAD_IDLE_US   = 100;           // idle time that starts programming
    localparam int WC_MS          = 10;            // write_cycle_time
    localparam int WSTART_NS      = 250;           // write_start_time
    localparam int ACC_NS         = 200;           // read access time
    localparam int WP_CYC     = (WP_NS * CLK_MHZ + 999) / 1000;
    localparam int BLC_MIN_CYC = (BLC_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int BLC_MAX_CYC = BLC_MAX_US * CLK_MHZ;           // longest: rounds down
    localparam int LOAD_IDLE_CYC = LOAD_IDLE_US * CLK_MHZ;
    localparam int WC_CYC     = WC_MS * 1000 * CLK_MHZ;
    localparam int WSTART_CYC = (WSTART_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC    = (ACC_NS * CLK_MHZ + 999) / 1000;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;     // bit0 release program reset
    localparam logic [7:0] OFF_ADDR   = 8'h04;     // target word address
    localparam logic [7:0] OFF_WDATA  = 8'h08;     // word to write
    localparam logic [7:0] OFF_CMD    = 8'h0c;     // operation start
    localparam logic [7:0] OFF_STATUS = 8'h10;     // state, w1c refused
    localparam logic [7:0] OFF_RDATA  = 8'h14;     // last word read
    localparam int ST_BUSY = 0;
    localparam int ST_OPEN = 1;
    localparam int ST_PROG = 2;
    localparam int ST_RDY  = 3;
    localparam int ST_REF  = 4;
    localparam int ST_PROT = 5;

    // ****************************************
    // operations and command bytes
    // ****************************************
    localparam logic [2:0] OP_WRITE   = 3'h1;      // plain word load
    localparam logic [2:0] OP_READ    = 3'h2;      // word read
    localparam logic [2:0] OP_PROT_ON = 3'h3;      // enable protection
    localparam logic [2:0] OP_PROT_OFF= 3'h4;      // remove protection
    localparam logic [2:0] OP_PWRITE  = 3'h5;      // write under protection
    localparam logic [16:0] A_5555 = 17'h05555;
    localparam logic [16:0] A_2AAA = 17'h02aaa;
    localparam logic [7:0]  B_AA = 8'haa;
    localparam logic [7:0]  B_55 = 8'h55;
    localparam logic [7:0]  B_A0 = 8'ha0;
    localparam logic [7:0]  B_80 = 8'h80;
    localparam logic [7:0]  B_20 = 8'h20;

    // ****************************************
    // strobe sequencer states
    // ****************************************
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_SETUP = 5'b00010,
        S_LOW   = 5'b00100,
        S_HIGH  = 5'b01000,
        S_READ  = 5'b10000
    } eph_state_t;
endpackage : eph_pkg

/* File: hw/eph_host.sv */
// eph_host: apb-controlled host that drives a page-write eeprom
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module eph_host #(
    parameter int LOAD_IDLE_CYC = eph_pkg::LOAD_IDLE_CYC, // idle before programming
    parameter int WC_CYC        = eph_pkg::WC_CYC         // write cycle time
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // eeprom pins
    output logic [16:0]      mem_addr,
    input  wire logic [31:0] mem_data_in,
    output logic [31:0]      mem_data_out,
    output logic             mem_data_oe,
    output logic             mem_ce_n,
    output logic             mem_oe_n,
    output logic             mem_we_n,
    output logic             program_reset_n,
    input  wire logic        ready_busy
);
    localparam int CW = 20;                       // width of long counters

    // ****************************************
    // sequence tables
    // ****************************************
    // number of strobes an operation needs
    function automatic logic [2:0] seq_len(input logic [2:0] op);
        case (op)
            eph_pkg::OP_PROT_ON:  seq_len = 3'h3;
            eph_pkg::OP_PROT_OFF: seq_len = 3'h6;
            eph_pkg::OP_PWRITE:   seq_len = 3'h4;
            default:              seq_len = 3'h1;
        endcase
    endfunction : seq_len

    // address of one step; last step of a data write is the user address
    function automatic logic [16:0] step_addr(input logic [2:0] op, input logic [2:0] i,
                                              input logic [16:0] ua);
        if (op == eph_pkg::OP_WRITE || (op == eph_pkg::OP_PWRITE && i == 3'h3)) begin
            step_addr = ua;
        end else if (i == 3'h1 || i == 3'h4) begin
            step_addr = eph_pkg::A_2AAA;
        end else begin
            step_addr = eph_pkg::A_5555;
        end
    endfunction : step_addr

    // data of one step, command bytes copied to all lanes
    function automatic logic [31:0] step_data(input logic [2:0] op, input logic [2:0] i,
                                              input logic [31:0] ud);
        logic [7:0] b;
        b = eph_pkg::B_AA;
        if (i == 3'h1 || i == 3'h4) begin
            b = eph_pkg::B_55;
        end else if (i == 3'h2) begin
            b = (op == eph_pkg::OP_PROT_OFF) ? eph_pkg::B_80 : eph_pkg::B_A0;
        end else if (i == 3'h5) begin
            b = eph_pkg::B_20;
        end
        if (op == eph_pkg::OP_WRITE || (op == eph_pkg::OP_PWRITE && i == 3'h3)) begin
            step_data = ud;
        end else begin
            step_data = {4{b}};
        end
    endfunction : step_data

    // ****************************************
    // state
    // ****************************************
    eph_pkg::eph_state_t st_reg, st_next;         // strobe sequencer
    logic          ctrl_reg, ctrl_next;           // software reset release
    logic [16:0]   addr_reg, addr_next;           // user address
    logic [31:0]   wdata_reg, wdata_next;         // user data
    logic [31:0]   rdata_reg, rdata_next;         // captured read word
    logic [2:0]    op_reg, op_next;               // running operation
    logic [2:0]    idx_reg, idx_next;             // step inside sequence
    logic [CW-1:0] tmr_reg, tmr_next;             // phase timer
    logic [CW-1:0] gap_reg, gap_next;             // time since last fall
    logic [CW-1:0] wc_reg, wc_next;               // time left in write cycle
    logic [CW-1:0] ws_reg, ws_next;               // time since programming began
    logic          open_reg, open_next;           // page load in progress
    logic          prog_reg, prog_next;           // device programming
    logic [9:0]    page_reg, page_next;           // page of open load
    logic          ref_reg, ref_next;             // sticky refused flag
    logic          prot_reg, prot_next;           // believed protection state
    logic [16:0]   ma_reg, ma_next;               // pin address
    logic [31:0]   md_reg, md_next;               // pin data
    logic          moe_reg, moe_next;             // pin data enable
    logic          ce_reg, ce_next;               // chip select, low active
    logic          oe_reg, oe_next;               // output enable, low active
    logic          we_reg, we_next;               // write strobe, low active
    logic          pr_reg, pr_next;               // program reset pin
    logic          wr_acc;                        // apb write access
    logic          bad;                           // start refused
    logic          is_wr;                         // op is a data load

    // ****************************************
    // apb read side
    // ****************************************
    assign pready = 1'b1;                         // zero wait states
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            eph_pkg::OFF_CTRL:   prdata = {31'h0000_0000, ctrl_reg};
            eph_pkg::OFF_ADDR:   prdata = {15'h0000, addr_reg};
            eph_pkg::OFF_WDATA:  prdata = wdata_reg;
            eph_pkg::OFF_CMD:    prdata = {29'h0000_0000, op_reg};
            eph_pkg::OFF_STATUS: prdata = {26'h000_0000, prot_reg, ref_reg, ready_busy,
                                           prog_reg, open_reg, st_reg != eph_pkg::S_IDLE};
            eph_pkg::OFF_RDATA:  prdata = rdata_reg;
            default:             pslverr = psel & penable;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;   ctrl_next = ctrl_reg;  addr_next = addr_reg;
        wdata_next = wdata_reg; rdata_next = rdata_reg; op_next = op_reg;
        idx_next = idx_reg; tmr_next = tmr_reg;    page_next = page_reg;
        ref_next = ref_reg; prot_next = prot_reg;  ma_next = ma_reg;
        md_next = md_reg;   moe_next = moe_reg;    ce_next = ce_reg;
        oe_next = oe_reg;   we_next = we_reg;      open_next = open_reg;
        prog_next = prog_reg;
        wr_acc = psel & penable & pwrite;
        is_wr = (pwdata[2:0] == eph_pkg::OP_WRITE) || (pwdata[2:0] == eph_pkg::OP_PWRITE);
        // background timers
        gap_next = (gap_reg < CW'(LOAD_IDLE_CYC)) ? gap_reg + 1'b1 : gap_reg;
        wc_next  = (wc_reg != '0) ? wc_reg - 1'b1 : wc_reg;
        ws_next  = (ws_reg < CW'(eph_pkg::WSTART_CYC)) ? ws_reg + 1'b1 : ws_reg;
        // idle strobes after the last byte: device starts programming
        if (open_reg && gap_reg >= CW'(LOAD_IDLE_CYC) && st_reg == eph_pkg::S_IDLE) begin
            open_next = 1'b0;
            prog_next = 1'b1;
            ws_next   = '0;
        end
        // programming ends on ready after write start time, or cycle time out
        if (prog_reg && ((ready_busy && ws_reg >= CW'(eph_pkg::WSTART_CYC))
                         || wc_reg == '0)) begin
            prog_next = 1'b0;
        end
        // refusal checks for a command start
        bad = !pr_reg || prog_reg || st_reg != eph_pkg::S_IDLE
              || pwdata[2:0] == 3'h0 || pwdata[2:0] > eph_pkg::OP_PWRITE;
        if (open_reg && pwdata[2:0] != eph_pkg::OP_READ
            && (gap_reg > CW'(eph_pkg::BLC_MAX_CYC)
                || (is_wr && addr_reg[16:7] != page_reg))) begin
            bad = 1'b1;
        end
        if (open_reg && pwdata[2:0] == eph_pkg::OP_READ) begin
            bad = 1'b1;                           // a read would break the page load
        end
        // register writes
        if (wr_acc) begin
            case (paddr)
                eph_pkg::OFF_CTRL:   ctrl_next = pwdata[0];
                eph_pkg::OFF_ADDR:   addr_next = pwdata[16:0];
                eph_pkg::OFF_WDATA:  wdata_next = pwdata;
                eph_pkg::OFF_STATUS: ref_next = ref_reg & ~pwdata[eph_pkg::ST_REF];
                eph_pkg::OFF_CMD: begin
                    if (bad) begin
                        ref_next = 1'b1;
                    end else begin
                        op_next  = pwdata[2:0];
                        idx_next = 3'h0;
                        st_next  = eph_pkg::S_SETUP;
                    end
                end
                default: ;
            endcase
        end
        // strobe sequencer
        case (st_reg)
            eph_pkg::S_IDLE: begin
                ce_next = 1'b1; we_next = 1'b1; oe_next = 1'b1; moe_next = 1'b0;
                tmr_next = '0;
            end
            eph_pkg::S_SETUP: begin
                // address and data stable before the strobe falls
                ce_next = 1'b0;
                if (op_reg == eph_pkg::OP_READ) begin
                    ma_next  = addr_reg;
                    oe_next  = 1'b0;
                    tmr_next = '0;
                    st_next  = eph_pkg::S_READ;
                end else begin
                    ma_next  = step_addr(op_reg, idx_reg, addr_reg);
                    md_next  = step_data(op_reg, idx_reg, wdata_reg);
                    moe_next = 1'b1;
                    oe_next  = 1'b1;
                    tmr_next = '0;
                    st_next  = eph_pkg::S_LOW;
                end
            end
            eph_pkg::S_LOW: begin
                // strobe low far longer than a glitch; address latched at fall
                we_next  = 1'b0;
                tmr_next = tmr_reg + 1'b1;
                if (tmr_reg == '0) begin
                    gap_next  = '0;
                    open_next = 1'b1;
                    if (!open_reg) begin
                        page_next = ma_reg[16:7];
                    end
                end
                if (tmr_reg >= CW'(eph_pkg::WP_CYC)) begin
                    we_next  = 1'b1;              // data latched on this rise
                    wc_next  = CW'(WC_CYC);
                    tmr_next = '0;
                    st_next  = eph_pkg::S_HIGH;
                end
            end
            eph_pkg::S_HIGH: begin
                // hold data past the rise, then space the next byte
                tmr_next = tmr_reg + 1'b1;
                if (tmr_reg >= CW'(eph_pkg::BLC_MIN_CYC)) begin
                    tmr_next = '0;
                    if (idx_reg == seq_len(op_reg) - 3'h1) begin
                        st_next = eph_pkg::S_IDLE;
                        if (op_reg == eph_pkg::OP_PROT_ON || op_reg == eph_pkg::OP_PWRITE) begin
                            prot_next = 1'b1;
                        end else if (op_reg == eph_pkg::OP_PROT_OFF) begin
                            prot_next = 1'b0;
                        end
                    end else begin
                        idx_next = idx_reg + 3'h1;
                        st_next  = eph_pkg::S_SETUP;
                    end
                end
            end
            eph_pkg::S_READ: begin
                // wait access time then capture the word
                tmr_next = tmr_reg + 1'b1;
                if (tmr_reg >= CW'(eph_pkg::ACC_CYC)) begin
                    rdata_next = mem_data_in;
                    st_next    = eph_pkg::S_IDLE;
                end
            end
            default: st_next = eph_pkg::S_IDLE;
        endcase
        // reset pin follows software but never drops inside a write cycle
        pr_next = ctrl_next | (wc_reg != '0);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= eph_pkg::S_IDLE; ctrl_reg <= 1'b0; addr_reg <= '0;
            wdata_reg <= '0; rdata_reg <= '0; op_reg <= '0; idx_reg <= '0;
            tmr_reg <= '0; gap_reg <= '0; wc_reg <= '0; ws_reg <= '0;
            open_reg <= 1'b0; prog_reg <= 1'b0; page_reg <= '0; ref_reg <= 1'b0;
            prot_reg <= 1'b0;
            ma_reg <= '0; md_reg <= '0; moe_reg <= 1'b0;
            ce_reg <= 1'b1; oe_reg <= 1'b1; we_reg <= 1'b1;
            pr_reg <= 1'b0;
        end else begin
            st_reg <= st_next; ctrl_reg <= ctrl_next; addr_reg <= addr_next;
            wdata_reg <= wdata_next; rdata_reg <= rdata_next; op_reg <= op_next;
            idx_reg <= idx_next; tmr_reg <= tmr_next; gap_reg <= gap_next;
            wc_reg <= wc_next; ws_reg <= ws_next; open_reg <= open_next;
            prog_reg <= prog_next; page_reg <= page_next; ref_reg <= ref_next;
            prot_reg <= prot_next; ma_reg <= ma_next; md_reg <= md_next;
            moe_reg <= moe_next; ce_reg <= ce_next; oe_reg <= oe_next;
            we_reg <= we_next; pr_reg <= pr_next;
        end
    end

    // pins straight from flops
    assign mem_addr        = ma_reg;
    assign mem_data_out    = md_reg;
    assign mem_data_oe     = moe_reg;
    assign mem_ce_n        = ce_reg;
    assign mem_oe_n        = oe_reg;
    assign mem_we_n        = we_reg;
    assign program_reset_n = pr_reg;
endmodule : eph_host
`default_nettype wire

/* File: dv/eph_checker.sv */
// eph_checker: port-level assertions for the eeprom host
`timescale 1ns/10ps
`default_nettype none
module eph_checker #(
    parameter int LOAD_IDLE_CYC = 200,
    parameter int WC_CYC        = 2000
) (
    // clock, reset, apb
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // eeprom pins
    input wire logic [16:0] mem_addr,
    input wire logic [31:0] mem_data_in,
    input wire logic [31:0] mem_data_out,
    input wire logic        mem_data_oe,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic        program_reset_n,
    input wire logic        ready_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // write strobe low with chip enabled and outputs off
    sequence s_we_low;
        (!mem_we_n && !mem_ce_n && mem_oe_n)[*8];
    endsequence
    a_apb_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (psel && penable && !pwrite && paddr > 8'h14
        |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    a_reset_holds_prst: assert property ($rose(rst_b) |-> !program_reset_n)
        else $error("program reset released by reset");
    a_prst_no_write: assert property (!program_reset_n |-> mem_we_n)
        else $error("write strobe while program reset low");
    a_we_pulse_width: assert property ($fell(mem_we_n)
        |-> s_we_low ##27 !mem_we_n ##1 mem_we_n) else $error("write strobe width wrong");
    a_addr_stable_low: assert property (!mem_we_n && $past(!mem_we_n)
        |-> $stable(mem_addr) && $stable(mem_data_out)) else $error("address moved");
    a_data_hold_rise: assert property ($rose(mem_we_n) |-> mem_data_oe && !mem_ce_n
        && $stable(mem_data_out) && $stable(mem_addr)) else $error("data not held");
    a_read_strobes: assert property (!mem_oe_n |-> mem_we_n
        && !mem_data_oe && !mem_ce_n) else $error("read with write strobe or drive");
    a_prst_after_data: assert property ($rose(mem_we_n) |-> program_reset_n[*8])
        else $error("program reset dropped after data");
endmodule : eph_checker
bind eph_host eph_checker #(.LOAD_IDLE_CYC(LOAD_IDLE_CYC), .WC_CYC(WC_CYC)) i_chk (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .program_reset_n(program_reset_n), .ready_busy(ready_busy));
`default_nettype wire

/* File: dv/eph_mem_model.sv */
// eph_mem_model: behavioural page-write eeprom
`timescale 1ns/10ps
`default_nettype none
module eph_mem_model #(
    parameter int IDLE = 200,
    parameter int BUSY = 1500
) (
    // clock and pins from the host
    input wire logic        clock,
    input wire logic [16:0] mem_addr,
    input wire logic [31:0] mem_data_out,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic        program_reset_n,
    // pins to the host
    output logic     [31:0] mem_data_in,
    output logic            ready_busy
);
    logic [31:0] mem [logic [16:0]];      // stored words
    logic [16:0] qa[$], sa[$], lat_a;     // loaded and staged addresses
    logic [31:0] qd[$], sd[$], last;      // loaded and staged data
    logic        prot = 1'b0;             // starts unprotected
    int          low_n = 0, idle_n = 0, busy_n = 0, s;
    initial mem_data_in = 32'h0;
    initial ready_busy = 1'b1;
    // command word with one byte on every lane
    function automatic logic hit(int i, logic [16:0] a, logic [7:0] b);
        return i < qa.size() && qd[i] == {4{b}}
            && (qa[i] == a || (a == 17'h02aaa && qa[i] == 17'h0aaaa));
    endfunction : hit
    // sort the page into commands and data
    task automatic decode();
        logic pre;
        pre = hit(0, 17'h05555, 8'haa) && hit(1, 17'h02aaa, 8'h55);
        s = prot ? qa.size() : 0;         // plain writes dropped while protected
        if (pre && hit(2, 17'h05555, 8'h80) && hit(3, 17'h05555, 8'haa)
            && hit(4, 17'h02aaa, 8'h55) && hit(5, 17'h05555, 8'h20)) begin
            prot = 1'b0;
            s = 6;
        end else if (pre && hit(2, 17'h05555, 8'ha0)) begin
            prot = 1'b1;
            s = 3;
        end
        for (int i = s; i < qa.size(); i++) begin
            sa.push_back(qa[i]);
            sd.push_back(qd[i]);
        end
        qa.delete();
        qd.delete();
    endtask : decode
    // strobe watcher, programming timer and read port
    always @(posedge clock) begin
        if (!program_reset_n) begin       // ignore and abort
            qa.delete();
            sa.delete();
            qd.delete();
            sd.delete();
            busy_n = 0;
            low_n = 0;
        end else if (!mem_we_n && !mem_ce_n) begin
            if (low_n == 0) lat_a = mem_addr;
            low_n++;
        end else begin
            if (low_n > 2 && busy_n == 0) begin    // glitch or busy load dropped
                qa.push_back(lat_a);
                qd.push_back(mem_data_out);
                last = mem_data_out;
                idle_n = 0;
            end
            low_n = 0;
            if (qa.size() > 0 && mem_ce_n && ++idle_n >= IDLE) begin
                decode();
                busy_n = BUSY;
            end else if (busy_n > 0 && --busy_n == 0) begin
                foreach (sa[i]) mem[sa[i]] = sd[i];
                sa.delete();
                sd.delete();
            end
        end
        if (program_reset_n && !mem_ce_n && !mem_oe_n && mem_we_n)
            mem_data_in <= busy_n > 0 ? last ^ 32'h80808080
                : (mem.exists(mem_addr) ? mem[mem_addr] : 32'hffffffff);
        else
            mem_data_in <= ~mem_data_in;           // released bus keeps moving
        ready_busy <= busy_n == 0 && qa.size() == 0;
    end
endmodule : eph_mem_model
`default_nettype wire

/* File: dv/tb_top.sv */
// tb_top: apb-driven test of the eeprom host with the memory model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0, rst_b = 1'b0;           // clock and reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, mem_data_in, mem_data_out, rdat;
    logic [16:0] mem_addr;
    logic        pready, pslverr, mem_data_oe, mem_ce_n, mem_oe_n, mem_we_n;
    logic        program_reset_n, ready_busy, rerr;
    int          n_mismatch = 0, checked = 0;
    eph_host #(.LOAD_IDLE_CYC(200), .WC_CYC(2000)) i_eph_host (.clock(clock), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
        .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
        .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
        .program_reset_n(program_reset_n), .ready_busy(ready_busy));
    eph_mem_model #(.IDLE(200), .BUSY(1500)) i_eph_mem_model (.clock(clock),
        .mem_addr(mem_addr), .mem_data_out(mem_data_out), .mem_ce_n(mem_ce_n),
        .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .program_reset_n(program_reset_n),
        .mem_data_in(mem_data_in), .ready_busy(ready_busy));
    initial forever #5 clock = ~clock;
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            close_out();
        end
        @(posedge clock);
    endtask : apb
    // poll one status bit until it reaches a value
    task automatic wait_st(input int b, input logic v);
        for (int i = 0; i < 3000; i++) begin
            apb(1'b0, eph_pkg::OFF_STATUS, 32'h0);
            if (rdat[b] === v) return;
        end
        n_mismatch++;
        close_out();
    endtask : wait_st
    task automatic op(input logic [2:0] o);
        apb(1'b1, eph_pkg::OFF_CMD, {29'h0, o});
        wait_st(eph_pkg::ST_BUSY, 1'b0);
    endtask : op
    task automatic store(input logic [16:0] a, input logic [31:0] d, input logic [2:0] o);
        apb(1'b1, eph_pkg::OFF_ADDR, {15'h0, a});
        apb(1'b1, eph_pkg::OFF_WDATA, d);
        op(o);
    endtask : store
    task automatic commit();
        wait_st(eph_pkg::ST_PROG, 1'b1);
        wait_st(eph_pkg::ST_PROG, 1'b0);
    endtask : commit
    task automatic fetch(input logic [16:0] a);
        apb(1'b1, eph_pkg::OFF_ADDR, {15'h0, a});
        op(eph_pkg::OP_READ);
        apb(1'b0, eph_pkg::OFF_RDATA, 32'h0);
    endtask : fetch
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        chk({31'h0, program_reset_n}, 32'h0);
        @(posedge clock);
        apb(1'b0, eph_pkg::OFF_STATUS, 32'h0);
        chk(rdat, 32'h00000008);
        apb(1'b0, 8'h40, 32'h0);
        chk({rdat[31:1], rerr}, 32'h00000001);
        apb(1'b1, eph_pkg::OFF_CMD, {29'h0, eph_pkg::OP_WRITE});
        apb(1'b0, eph_pkg::OFF_STATUS, 32'h0);
        chk(rdat, 32'h00000018);
        apb(1'b1, eph_pkg::OFF_STATUS, 32'h10);
        apb(1'b1, eph_pkg::OFF_CTRL, 32'h1);
        @(negedge clock);
        chk({31'h0, program_reset_n}, 32'h1);
        @(posedge clock);
        store(17'h00100, 32'h11111111, eph_pkg::OP_WRITE);
        store(17'h0017f, 32'h22222222, eph_pkg::OP_WRITE);
        store(17'h00200, 32'h99999999, eph_pkg::OP_WRITE);
        apb(1'b0, eph_pkg::OFF_STATUS, 32'h0);
        chk(rdat & 32'h12, 32'h12);
        apb(1'b1, eph_pkg::OFF_STATUS, 32'h10);
        commit();
        fetch(17'h00100);
        chk(rdat, 32'h11111111);
        fetch(17'h0017f);
        chk(rdat, 32'h22222222);
        op(eph_pkg::OP_PROT_ON);
        commit();
        apb(1'b0, eph_pkg::OFF_STATUS, 32'h0);
        chk(rdat & 32'h20, 32'h20);
        store(17'h00100, 32'h33333333, eph_pkg::OP_WRITE);
        commit();
        fetch(17'h00100);
        chk(rdat, 32'h11111111);
        store(17'h00100, 32'h44444444, eph_pkg::OP_PWRITE);
        commit();
        fetch(17'h00100);
        chk(rdat, 32'h44444444);
        op(eph_pkg::OP_PROT_OFF);
        commit();
        store(17'h0017f, 32'h55555555, eph_pkg::OP_WRITE);
        commit();
        fetch(17'h0017f);
        chk(rdat, 32'h55555555);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
